// ---- rtl/flow_seq_pkg.sv ----
package flow_seq_pkg;
   localparam logic [7:0]  OP_JUMP_ALWAYS   = 8'h16;
   localparam logic [7:0]  OP_CALL_SUB      = 8'h17;
   localparam logic [7:0]  OP_RETURN_SUB    = 8'h18;
   localparam logic [7:0]  OP_WAIT          = 8'h1B;
   localparam logic [7:0]  OP_CLEAR_ERR     = 8'h24;
   localparam logic [7:0]  OP_COND_JUMP     = 8'h15;
   localparam logic [7:0]  WAIT_TICKS       = 8'h00;
   localparam logic [7:0]  WAIT_POS         = 8'h01;
   localparam logic [7:0]  WAIT_HOME_SW     = 8'h02;
   localparam logic [7:0]  WAIT_END_SW      = 8'h03;
   localparam logic [7:0]  WAIT_HOMING_DONE = 8'h04;
   localparam logic [7:0]  COND_TIMEOUT     = 8'h08;
   localparam int          STACK_DEPTH      = 8;
   localparam int          PC_W             = 16;
   localparam int          MOTOR_W          = 8;
   localparam int          NUM_MOTORS       = 1;
   localparam int          CLK_HZ           = 125000000;
   localparam int          TICK_MS          = 10;
   localparam int          TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
   localparam logic [PC_W-1:0] PC_RESET     = 16'h0000;
   localparam logic [31:0] VAL_USE_ACCU     = 32'hFFFFFFFF;
endpackage

// ---- rtl/program_flow_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module program_flow_sequencer (
   // Clock and reset
   input  wire logic                              i_ref_clk,
   input  wire logic                              i_srst,
   // Decoded instruction
   input  wire logic                              i_instr_valid,
   input  wire logic [7:0]                        i_opcode,
   input  wire logic [7:0]                        i_type,
   input  wire logic [7:0]                        i_motor,
   input  wire logic [31:0]                       i_value,
   input  wire logic [31:0]                       i_accu,
   // Motion status pins
   input  wire logic                              i_pos_reached,
   input  wire logic                              i_home_switch,
   input  wire logic                              i_end_switch_left,
   input  wire logic                              i_end_switch_right,
   input  wire logic                              i_homing_done,
   // Sequencer state
   output logic                                   o_instr_ready,
   output logic [flow_seq_pkg::PC_W-1:0]          o_pc,
   output logic                                   o_waiting,
   output logic                                   o_timeout_error_flag,
   output logic                                   o_cond_timeout_taken,
   output logic [3:0]                             o_stack_level
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } state_t;

   // Three-stage sampling of asynchronous motion status
   logic [4:0] s1_r, s2_r, s3_r, stat_r, stat_nxt;
   logic [4:0] raw;
   assign raw = {i_homing_done, i_end_switch_right, i_end_switch_left,
                 i_home_switch, i_pos_reached};

   // A level counts once the last two stages agree
   always_comb begin
      stat_nxt = stat_r;
      for (int k = 0; k < 5; k++) begin
         if (s2_r[k] == s3_r[k]) begin
            stat_nxt[k] = s3_r[k];
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         s1_r   <= 5'h00;
         s2_r   <= 5'h00;
         s3_r   <= 5'h00;
         stat_r <= 5'h00;
      end else begin
         s1_r   <= raw;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         stat_r <= stat_nxt;
      end
   end

   function automatic logic cond_met(input logic [7:0] t, input logic [4:0] st);
      logic r;
      r = 1'b0;
      case (t)
         flow_seq_pkg::WAIT_POS:         r = st[0];
         flow_seq_pkg::WAIT_HOME_SW:     r = st[1];
         flow_seq_pkg::WAIT_END_SW:      r = st[2] | st[3];
         flow_seq_pkg::WAIT_HOMING_DONE: r = st[4];
         default:                        r = 1'b0;
      endcase
      return r;
   endfunction

   // Free-running 10 ms tick
   logic [23:0] div_r, div_nxt;
   logic        tick;
   assign tick = (div_r == 24'(flow_seq_pkg::TICK_CYCLES - 1));

   always_comb begin
      div_nxt = tick ? 24'h000000 : div_r + 24'h000001;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         div_r <= 24'h000000;
      end else begin
         div_r <= div_nxt;
      end
   end

   state_t                        state_r, state_nxt;
   logic [flow_seq_pkg::PC_W-1:0] pc_r, pc_nxt;
   logic [flow_seq_pkg::PC_W-1:0] stack_r [flow_seq_pkg::STACK_DEPTH];
   logic [flow_seq_pkg::PC_W-1:0] stack_nxt [flow_seq_pkg::STACK_DEPTH];
   logic [3:0]                    sp_r, sp_nxt;
   logic [31:0]                   cnt_r, cnt_nxt;
   logic [7:0]                    wtype_r, wtype_nxt;
   logic                          tmo_r, tmo_nxt;
   logic                          jc_r, jc_nxt;
   logic [31:0]                   ticks;

   // Negative accumulator is the program's fault; treated as unsigned
   assign ticks = (i_value == flow_seq_pkg::VAL_USE_ACCU) ? i_accu : i_value;

   assign o_instr_ready = (state_r == ST_IDLE);

   always_comb begin
      state_nxt = state_r;
      pc_nxt    = pc_r;
      stack_nxt = stack_r;
      sp_nxt    = sp_r;
      cnt_nxt   = cnt_r;
      wtype_nxt = wtype_r;
      tmo_nxt   = tmo_r;
      jc_nxt    = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (i_instr_valid) begin
               pc_nxt = pc_r + 16'h0001;
               case (i_opcode)
                  flow_seq_pkg::OP_JUMP_ALWAYS: begin
                     pc_nxt = i_value[flow_seq_pkg::PC_W-1:0];
                  end
                  flow_seq_pkg::OP_CALL_SUB: begin
                     // Full stack: whole call dropped, PC just steps on
                     if (sp_r < 4'(flow_seq_pkg::STACK_DEPTH)) begin
                        stack_nxt[sp_r[2:0]] = pc_r;
                        sp_nxt = sp_r + 4'h1;
                        pc_nxt = i_value[flow_seq_pkg::PC_W-1:0];
                     end
                  end
                  flow_seq_pkg::OP_RETURN_SUB: begin
                     if (sp_r != 4'h0) begin
                        // Saved PC is the call's own address, resume after it
                        pc_nxt = stack_r[3'(sp_r - 4'h1)] + 16'h0001;
                        sp_nxt = sp_r - 4'h1;
                     end
                  end
                  flow_seq_pkg::OP_WAIT: begin
                     wtype_nxt = i_type;
                     cnt_nxt   = ticks;
                     if (i_type == flow_seq_pkg::WAIT_TICKS) begin
                        if (ticks != 32'h00000000) begin
                           pc_nxt    = pc_r;
                           state_nxt = ST_WAIT;
                        end
                     end else if (i_type <= flow_seq_pkg::WAIT_HOMING_DONE &&
                                  !cond_met(i_type, stat_r)) begin
                        pc_nxt    = pc_r;
                        state_nxt = ST_WAIT;
                     end
                  end
                  flow_seq_pkg::OP_CLEAR_ERR: begin
                     tmo_nxt = 1'b0;
                  end
                  flow_seq_pkg::OP_COND_JUMP: begin
                     if (i_type == flow_seq_pkg::COND_TIMEOUT && tmo_r) begin
                        pc_nxt = i_value[flow_seq_pkg::PC_W-1:0];
                        jc_nxt = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_WAIT: begin
            if (wtype_r == flow_seq_pkg::WAIT_TICKS) begin
               if (tick) begin
                  cnt_nxt = cnt_r - 32'h00000001;
                  if (cnt_r == 32'h00000001) begin
                     state_nxt = ST_IDLE;
                     pc_nxt    = pc_r + 16'h0001;
                  end
               end
            end else if (cond_met(wtype_r, stat_r)) begin
               state_nxt = ST_IDLE;
               pc_nxt    = pc_r + 16'h0001;
            end else if (tick && cnt_r != 32'h00000000) begin
               cnt_nxt = cnt_r - 32'h00000001;
               if (cnt_r == 32'h00000001) begin
                  tmo_nxt   = 1'b1;
                  state_nxt = ST_IDLE;
                  pc_nxt    = pc_r + 16'h0001;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state_r <= ST_IDLE;
         pc_r    <= flow_seq_pkg::PC_RESET;
         sp_r    <= 4'h0;
         cnt_r   <= 32'h00000000;
         wtype_r <= 8'h00;
         tmo_r   <= 1'b0;
         jc_r    <= 1'b0;
         for (int k = 0; k < flow_seq_pkg::STACK_DEPTH; k++) begin
            stack_r[k] <= 16'h0000;
         end
      end else begin
         state_r <= state_nxt;
         pc_r    <= pc_nxt;
         sp_r    <= sp_nxt;
         cnt_r   <= cnt_nxt;
         wtype_r <= wtype_nxt;
         tmo_r   <= tmo_nxt;
         jc_r    <= jc_nxt;
         stack_r <= stack_nxt;
      end
   end

   assign o_pc                 = pc_r;
   assign o_waiting            = (state_r == ST_WAIT);
   assign o_timeout_error_flag = tmo_r;
   assign o_cond_timeout_taken = jc_r;
   assign o_stack_level        = sp_r;

   // Stack
   a_stack_bound: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      sp_r <= 4'h8)
      else $error("stack overflow");
   a_full_call_ignored: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_CALL_SUB
       && sp_r == 4'h8) |=> (sp_r == 4'h8 && pc_r == $past(pc_r) + 16'h0001))
      else $error("full call not ignored");
   a_call_push: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_CALL_SUB
       && sp_r < 4'h8) |=> (sp_r == $past(sp_r) + 4'h1
       && stack_r[$past(sp_r[2:0])] == $past(pc_r)
       && pc_r == $past(i_value[15:0])))
      else $error("call push wrong");
   a_return_pop: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_RETURN_SUB
       && sp_r != 4'h0) |=> (sp_r == $past(sp_r) - 4'h1
       && pc_r == $past(stack_r[sp_r[2:0] - 3'h1]) + 16'h0001))
      else $error("return pop wrong");
   a_empty_return: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_RETURN_SUB
       && sp_r == 4'h0) |=> (sp_r == 4'h0 && pc_r == $past(pc_r) + 16'h0001))
      else $error("empty return changed");

   // Jumps
   a_jump_load: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_JUMP_ALWAYS)
      |=> pc_r == $past(i_value[15:0]))
      else $error("jump target wrong");
   a_cond_taken: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_COND_JUMP
       && i_type == flow_seq_pkg::COND_TIMEOUT && tmo_r)
      |=> (o_cond_timeout_taken && pc_r == $past(i_value[15:0])))
      else $error("timeout jump not taken");
   a_cond_not_taken: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_COND_JUMP
       && !tmo_r) |=> (!o_cond_timeout_taken && pc_r == $past(pc_r) + 16'h0001))
      else $error("timeout jump taken without flag");

   // Waits
   a_wait_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_waiting && $past(o_waiting)) |-> $stable(pc_r))
      else $error("pc moved in wait");
   a_wait_enter: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_WAIT
       && i_type == flow_seq_pkg::WAIT_TICKS && ticks != 32'h00000000)
      |=> (o_waiting && pc_r == $past(pc_r) && cnt_r == $past(ticks)))
      else $error("tick wait not entered");
   a_accu_ticks: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_WAIT
       && i_value == flow_seq_pkg::VAL_USE_ACCU) |=> cnt_r == $past(i_accu))
      else $error("accumulator count not used");
   a_zero_ticks: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_WAIT
       && i_type == 8'h00 && i_value == 32'h0) |=> !o_waiting)
      else $error("zero wait stalled");
   a_tick_only: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_waiting && wtype_r == flow_seq_pkg::WAIT_TICKS && !tick) |=> o_waiting)
      else $error("tick wait left early");
   a_tick_expire: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_waiting && wtype_r == flow_seq_pkg::WAIT_TICKS && tick && cnt_r == 32'h00000001)
      |=> (!o_waiting && pc_r == $past(pc_r) + 16'h0001))
      else $error("tick wait overran");
   a_cond_release: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_waiting && wtype_r != flow_seq_pkg::WAIT_TICKS && cond_met(wtype_r, stat_r))
      |=> (!o_waiting && pc_r == $past(pc_r) + 16'h0001 && tmo_r == $past(tmo_r)))
      else $error("met condition not released");

   // Timeout flag
   a_timeout_set: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_waiting && wtype_r != flow_seq_pkg::WAIT_TICKS && !cond_met(wtype_r, stat_r)
       && tick && cnt_r == 32'h00000001) |=> (tmo_r && !o_waiting
       && pc_r == $past(pc_r) + 16'h0001))
      else $error("timeout not flagged");
   a_no_timeout: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_waiting && wtype_r != flow_seq_pkg::WAIT_TICKS && cnt_r == 32'h00000000)
      |=> tmo_r == $past(tmo_r))
      else $error("timeout without limit");
   a_flag_sticky: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      ($past(tmo_r) && !tmo_r) |-> ($past(i_opcode) == flow_seq_pkg::OP_CLEAR_ERR
      && $past(i_instr_valid)))
      else $error("flag lost");
   a_flag_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (o_instr_ready && i_instr_valid && i_opcode == flow_seq_pkg::OP_CLEAR_ERR)
      |=> !tmo_r)
      else $error("flag not cleared");

   // Tick divider
   a_tick_period: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      tick |=> div_r == 24'h000000)
      else $error("tick divider wrong");
   a_tick_bound: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      div_r <= 24'(flow_seq_pkg::TICK_CYCLES - 1))
      else $error("tick divider overran");

endmodule
`default_nettype wire

// ---- sim/program_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module program_host_model (
   // Clock and handshake
   input  wire logic        i_ref_clk,
   input  wire logic        i_instr_ready,
   // Instruction fields
   output logic             o_instr_valid,
   output logic [7:0]       o_opcode,
   output logic [7:0]       o_type,
   output logic [7:0]       o_motor,
   output logic [31:0]      o_value,
   output logic [31:0]      o_accu,
   // Motion status levels and handshake-stuck flag
   output logic [4:0]       o_status,
   output logic             o_stuck
);
   initial begin
      o_instr_valid = 1'b0;
      o_opcode      = 8'h00;
      o_type        = 8'h00;
      o_motor       = 8'h00;
      o_value       = 32'h0;
      o_accu        = 32'h0;
      o_status      = 5'h00;
      o_stuck       = 1'b0;
   end
   // Flow commands come only from the stored program
   task automatic issue(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] val);
      int n;
      n             = 0;
      o_opcode      = op;
      o_type        = ty;
      o_motor       = ~ty;
      o_value       = val;
      o_instr_valid = 1'b1;
      // Ready is judged one step after an edge, where it has settled
      while (i_instr_ready !== 1'b1 && n < 1000) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      // Taking edge; only then are the fields let go
      @(posedge i_ref_clk);
      o_stuck       = o_stuck | (n >= 1000);
      #1;
      o_instr_valid = 1'b0;
      // Released opcode, type and value flip (motor keeps its value), stale values never pass for live ones
      o_opcode      = ~op;
      o_type        = ~ty;
      o_value       = ~val;
   endtask
   task automatic set_status(input logic [4:0] s, input logic [30:0] acc);
      o_status = s;
      o_accu   = {1'b0, acc};
   endtask
endmodule
`default_nettype wire

// ---- sim/program_flow_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module program_flow_sequencer_tb_top;
   logic        i_ref_clk = 1'b0;
   logic        i_srst    = 1'b1;
   logic        valid, ready, waiting, flag, taken, stuck;
   logic [7:0]  opc, typ, mot;
   logic [31:0] val, accu;
   logic [4:0]  st;
   logic [15:0] pc;
   logic [3:0]  lvl;
   logic [31:0] rng = 32'h00004893;
   logic [15:0] exp_pc;
   logic [15:0] stk[$];
   logic [7:0]  ops[4];
   int          miscompares = 0;
   int          n_compared  = 0;
   always #4 i_ref_clk = ~i_ref_clk;
   program_host_model i_host (.i_ref_clk(i_ref_clk), .i_instr_ready(ready),
      .o_instr_valid(valid), .o_opcode(opc), .o_type(typ), .o_motor(mot), .o_value(val),
      .o_accu(accu), .o_status(st), .o_stuck(stuck));
   program_flow_sequencer i_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
      .i_instr_valid(valid), .i_opcode(opc), .i_type(typ), .i_motor(mot), .i_value(val),
      .i_accu(accu), .i_pos_reached(st[0]), .i_home_switch(st[1]),
      .i_end_switch_left(st[2]), .i_end_switch_right(st[3]), .i_homing_done(st[4]),
      .o_instr_ready(ready), .o_pc(pc), .o_waiting(waiting),
      .o_timeout_error_flag(flag), .o_cond_timeout_taken(taken), .o_stack_level(lvl));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   function automatic logic [7:0] wait_type(input int idx);
      return (idx == 0) ? 8'h01 : (idx == 1) ? 8'h02 : (idx <= 3) ? 8'h03 : 8'h04;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic flow(input logic [7:0] op, input logic [7:0] ty, input logic [15:0] v);
      i_host.issue(op, ty, {16'h0, v});
      if (op == flow_seq_pkg::OP_JUMP_ALWAYS) exp_pc = v;
      else if (op == flow_seq_pkg::OP_CALL_SUB && stk.size() < flow_seq_pkg::STACK_DEPTH) begin
         stk.push_back(exp_pc);
         exp_pc = v;
      end else if (op == flow_seq_pkg::OP_RETURN_SUB && stk.size() > 0) begin
         exp_pc = stk.pop_back() + 16'h0001;
      end else exp_pc++;
      // Looked at one step after the taking edge, while the jump pulse stands
      check({16'h0, pc}, {16'h0, exp_pc});
      check({28'h0, lvl}, stk.size());
      check({31'h0, taken}, 32'h0);
      @(posedge i_ref_clk);
      #1;
   endtask
   task automatic wait_cond(input int idx, input logic pre);
      logic [4:0] s;
      int         n;
      s = 5'h00;
      s[idx] = pre;
      i_host.set_status(s, rng[30:0]);
      repeat (6) @(posedge i_ref_clk);
      #1;
      i_host.issue(flow_seq_pkg::OP_WAIT, wait_type(idx), 32'h0);
      if (!pre) begin
         s = ~(5'h01 << idx);
         if (idx == 2 || idx == 3) s[3:2] = 2'b00;
         i_host.set_status(s, rng[30:0]);
         repeat (8) @(posedge i_ref_clk);
         #1;
         check({31'h0, waiting}, 32'h1);
         check({31'h0, ready}, 32'h0);
         check({16'h0, pc}, {16'h0, exp_pc});
         s[idx] = 1'b1;
         i_host.set_status(s, rng[30:0]);
      end
      n = 0;
      @(posedge i_ref_clk);
      #1;
      while (waiting !== 1'b0 && n < 40) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
      exp_pc++;
      check({16'h0, pc}, {16'h0, exp_pc});
      check({31'h0, flag}, 32'h0);
      i_host.set_status(5'h00, rng[30:0]);
      repeat (6) @(posedge i_ref_clk);
      #1;
   endtask
   initial begin
      ops = '{flow_seq_pkg::OP_JUMP_ALWAYS, flow_seq_pkg::OP_CALL_SUB,
              flow_seq_pkg::OP_RETURN_SUB, 8'h13};
      repeat (6) @(posedge i_ref_clk);
      #1;
      check({16'h0, pc}, {16'h0, flow_seq_pkg::PC_RESET});
      i_srst = 1'b0;
      exp_pc = flow_seq_pkg::PC_RESET;
      // Ninth call and ninth return must both be refused
      for (int i = 0; i < 9; i++) flow(flow_seq_pkg::OP_CALL_SUB, 8'h00, 16'h0100 + i);
      for (int i = 0; i < 9; i++) flow(flow_seq_pkg::OP_RETURN_SUB, 8'h00, 16'h0);
      flow(flow_seq_pkg::OP_COND_JUMP, flow_seq_pkg::COND_TIMEOUT, 16'h1234);
      check({30'h0, flag, taken}, 32'h0);
      flow(flow_seq_pkg::OP_CLEAR_ERR, 8'h00, 16'h0);
      for (int i = 0; i < 5; i++) begin
         wait_cond(i, 1'b0);
         wait_cond(i, 1'b1);
      end
      // Zero ticks direct, then zero ticks through the accumulator
      i_host.set_status(5'h00, 31'h0);
      i_host.issue(flow_seq_pkg::OP_WAIT, flow_seq_pkg::WAIT_TICKS, 32'h0);
      repeat (4) @(posedge i_ref_clk);
      #1;
      i_host.issue(flow_seq_pkg::OP_WAIT, flow_seq_pkg::WAIT_TICKS, flow_seq_pkg::VAL_USE_ACCU);
      repeat (4) @(posedge i_ref_clk);
      #1;
      exp_pc = exp_pc + 2;
      check({16'h0, pc}, {16'h0, exp_pc});
      for (int i = 0; i < 300; i++) begin
         rng = xs(rng);
         flow(ops[rng[1:0]], rng[15:8], rng[31:16]);
      end
      // Accumulator-fed tick wait stalls; a reset in mid-wait must end it
      i_host.set_status(5'h00, 31'h00000005);
      i_host.issue(flow_seq_pkg::OP_WAIT, flow_seq_pkg::WAIT_TICKS, flow_seq_pkg::VAL_USE_ACCU);
      repeat (8) @(posedge i_ref_clk);
      #1;
      check({31'h0, waiting}, 32'h1);
      check({16'h0, pc}, {16'h0, exp_pc});
      i_srst = 1'b1;
      repeat (2) @(posedge i_ref_clk);
      #1;
      check({11'h0, waiting, lvl, pc}, 32'h0);
      check({31'h0, stuck}, 32'h0);
      complete_run();
   end
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
endmodule
`default_nettype wire
